// file: logic/mscr_clk_div.sv
`timescale 1ns/100ps
module mscr_clk_div
    import mscr_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 ce_i,
    input  wire logic                 ext_clk_i,
    input  wire logic [DIV_LOG_W-1:0] div_log_i,
    output logic                      tick_o
);
    logic                 ext_q;
    logic [DIV_CNT_W-1:0] cnt;
    logic [DIV_CNT_W-1:0] mask;
    logic                 rise;

    always_comb begin
        mask = DIV_CNT_W'((9'h001 << div_log_i) - 9'h001);
    end

    assign rise   = ext_clk_i & ~ext_q;
    // one tick every 2**div_log_i rising edges of the external clock
    assign tick_o = rise && ((cnt & mask) == mask);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ext_q <= 1'b0;
            cnt   <= '0;
        end else if (ce_i) begin
            ext_q <= ext_clk_i;
            if (rise) begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule // mscr_clk_div

// file: logic/mscr_pkg.sv
package mscr_pkg;

    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned POS_W      = 24;
    localparam int unsigned DIV_LOG_W  = 4;
    localparam int unsigned DIV_CNT_W  = 8;
    localparam int unsigned DIV_LOG_MAX = 8;
    localparam int unsigned STEP_BITS  = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_POS     = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WIDTH   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OFFSET  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DIV1    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DIV2    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EXTFREQ = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FMODE   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_LEN1    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_LEN2    = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_CNT1    = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_CNT2    = 8'h30;

    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_SOURCE = 1;
    localparam int unsigned CTRL_TYPE   = 2;
    localparam int unsigned CTRL_COMMON = 3;
    localparam int unsigned CTRL_EXT1   = 4;
    localparam int unsigned CTRL_EXT2   = 5;

    localparam int unsigned FMODE_CH1_LSB = 0;
    localparam int unsigned FMODE_CH2_LSB = 2;
    localparam logic [1:0] FMODE_STANDARD  = 2'h0;
    localparam logic [1:0] FMODE_ARBITRARY = 2'h1;
    localparam logic [1:0] FMODE_SEQUENCE  = 2'h2;
    localparam logic [1:0] FMODE_OTHER     = 2'h3;

    localparam logic [POS_W-1:0]     POS_RESET   = 24'h000000;
    localparam logic [POS_W-1:0]     WIDTH_MIN   = 24'h000010;
    localparam logic [POS_W-1:0]     LEN_RESET   = 24'h000400;
    localparam logic [DIV_LOG_W-1:0] DIV_RESET   = 4'h0;
    localparam logic [POS_W-1:0]     WAVEFORM_COMPLETE_MARKER_SAMPLES = 24'h000010;

    typedef struct packed {
        logic ext2;
        logic ext1;
        logic common;
        logic waveform_complete_marker;
        logic source;
        logic enable;
    } mscr_ctrl_t;

    localparam mscr_ctrl_t CTRL_RESET = '0;

    typedef enum logic [1:0] {
        WAVEFORM_COMPLETE_MARKER_IDLE   = 2'b01,
        WAVEFORM_COMPLETE_MARKER_ACTIVE = 2'b10
    } mscr_waveform_complete_marker_state_t;

endpackage

// file: logic/mscr_sample_ctr.sv
`timescale 1ns/100ps
module mscr_sample_ctr
    import mscr_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             start_i,
    input  wire logic             run_i,
    input  wire logic             tick_i,
    input  wire logic [POS_W-1:0] len_i,
    input  wire logic [POS_W-1:0] load_i,
    output logic      [POS_W-1:0] pos_o,
    output logic                  last_o
);
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pos_o  <= '0;
            last_o <= 1'b0;
        end else if (ce_i) begin
            last_o <= 1'b0;
            if (start_i) begin
                pos_o <= load_i;
            end else if (run_i && tick_i) begin
                if (pos_o >= len_i - 24'h000001) begin
                    pos_o  <= '0;
                    last_o <= 1'b1;
                end else begin
                    pos_o <= pos_o + 24'h000001;
                end
            end
        end
    end
endmodule // mscr_sample_ctr

// file: logic/mscr_top.sv
// Contract
// - marker disabled after every power-up
// - disabled: no marker, indicator dark, driven low
// - marker source selectable on dual-channel builds
// - pulse or complete shapes; pulse min 16
// - complete marker ignores position and width
// - position in samples, 16-sample steps
// - default position is first sample
// - width 16 to length, 16-sample steps; upper end not capped at length, window cut at waveform end
// - common feed clocks both, locks second
// - second channel start offset, plus/minus length
// - offset inaccessible unless common feed
// - each channel picks internal or external clock
// - external clock only in arbitrary/sequence
// - external clock divided by 1..256 power-two
// - frequency setting gated by external selection
`timescale 1ns/100ps
module mscr_top
    import mscr_pkg::*;
#(
    parameter bit DUAL = 1'b1
) (
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic [1:0]        int_tick_i,
    input  wire logic              ext_clk_i,
    input  wire logic [1:0]        run_i,
    output logic      [1:0]        sample_tick_o,
    output logic                   marker_o,
    output logic                   led_o
);
    mscr_ctrl_t             ctrl;
    logic [POS_W-1:0]       mk_pos;
    logic [POS_W-1:0]       mk_width;
    logic signed [POS_W:0]  xoffset;
    logic [DIV_LOG_W-1:0]   div1;
    logic [DIV_LOG_W-1:0]   div2;
    logic [DATA_W-1:0]      ext_freq;
    logic                   ext_freq_set;
    logic [3:0]             fmode;
    logic [POS_W-1:0]       len1;
    logic [POS_W-1:0]       len2;
    logic [1:0]             ext_tick;
    logic [1:0]             tick;
    logic                   ext1_ok;
    logic                   ext2_ok;
    logic [1:0]             run_q;
    logic [1:0]             start;
    logic [POS_W-1:0]       pos1;
    logic [POS_W-1:0]       pos2;
    logic [1:0]             last;
    logic [POS_W-1:0]       len2_eff;
    logic [POS_W-1:0]       load2;
    logic                   run2;
    logic [POS_W-1:0]       sel_pos;
    logic [POS_W-1:0]       sel_len;
    logic                   sel_tick;
    logic                   sel_last;
    logic                   sel_run;
    logic                   in_window;
    mscr_waveform_complete_marker_state_t       wstate;
    logic [POS_W-1:0]       wcount;
    logic                   waveform_complete_marker_level;

    // the divider counter must hold 2**DIV_LOG_MAX rising edges
    if (DIV_CNT_W < DIV_LOG_MAX) begin : g_div_check
        $error("divider counter too narrow");
    end

    function automatic logic ext_allowed(input logic [1:0] m);
        return (m == FMODE_ARBITRARY) || (m == FMODE_SEQUENCE);
    endfunction

    function automatic logic [POS_W-1:0] step_floor(input logic [DATA_W-1:0] v);
        return {v[POS_W-1:STEP_BITS], {STEP_BITS{1'b0}}};
    endfunction

    // write side
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl <= CTRL_RESET;
        end else if (ce_i && wr_i && addr_i == OFS_CTRL) begin
            ctrl.enable <= wdata_i[CTRL_ENABLE];
            ctrl.source <= DUAL ? wdata_i[CTRL_SOURCE] : 1'b0;
            ctrl.waveform_complete_marker   <= wdata_i[CTRL_TYPE];
            ctrl.common <= DUAL ? wdata_i[CTRL_COMMON] : 1'b0;
            ctrl.ext1   <= wdata_i[CTRL_EXT1] && ext_allowed(fmode[FMODE_CH1_LSB +: 2]);
            if (!ctrl.common || !wdata_i[CTRL_COMMON] || !DUAL) begin
                ctrl.ext2 <= DUAL && !wdata_i[CTRL_COMMON] && wdata_i[CTRL_EXT2]
                             && ext_allowed(fmode[FMODE_CH2_LSB +: 2]);
            end else begin
                ctrl.ext2 <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mk_pos   <= POS_RESET;
            mk_width <= WIDTH_MIN;
        end else if (ce_i && wr_i) begin
            if (addr_i == OFS_POS) begin
                mk_pos <= step_floor(wdata_i);
            end else if (addr_i == OFS_WIDTH) begin
                if (step_floor(wdata_i) < WIDTH_MIN) begin
                    mk_width <= WIDTH_MIN;
                end else begin
                    mk_width <= step_floor(wdata_i);
                end
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            xoffset <= '0;
        end else if (ce_i && wr_i && addr_i == OFS_OFFSET && ctrl.common) begin
            xoffset <= $signed(wdata_i[POS_W:0]);
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div1 <= DIV_RESET;
            div2 <= DIV_RESET;
            fmode <= '0;
            len1 <= LEN_RESET;
            len2 <= LEN_RESET;
        end else if (ce_i && wr_i) begin
            if (addr_i == OFS_DIV1) begin
                if (wdata_i[DIV_LOG_W-1:0] <= DIV_LOG_W'(DIV_LOG_MAX)) begin
                    div1 <= wdata_i[DIV_LOG_W-1:0];
                end
            end else if (addr_i == OFS_DIV2) begin
                if (!ctrl.common && DUAL
                    && wdata_i[DIV_LOG_W-1:0] <= DIV_LOG_W'(DIV_LOG_MAX)) begin
                    div2 <= wdata_i[DIV_LOG_W-1:0];
                end
            end else if (addr_i == OFS_FMODE) begin
                fmode <= wdata_i[3:0];
            end else if (addr_i == OFS_LEN1) begin
                len1 <= (wdata_i[POS_W-1:0] == '0) ? LEN_RESET : wdata_i[POS_W-1:0];
            end else if (addr_i == OFS_LEN2) begin
                if (!ctrl.common && DUAL) begin
                    len2 <= (wdata_i[POS_W-1:0] == '0) ? LEN_RESET : wdata_i[POS_W-1:0];
                end
            end
        end
    end

    // frequency setting only while some channel asks for the external clock
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ext_freq     <= '0;
            ext_freq_set <= 1'b0;
        end else if (ce_i) begin
            if (!ext1_ok && !ext2_ok) begin
                ext_freq_set <= 1'b0;
            end else if (wr_i && addr_i == OFS_EXTFREQ) begin
                ext_freq     <= wdata_i;
                ext_freq_set <= 1'b1;
            end
        end
    end

    // read side
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (rd_i) begin
                if (addr_i == OFS_CTRL) begin
                    rdata_o <= DATA_W'(ctrl);
                end else if (addr_i == OFS_POS) begin
                    rdata_o <= DATA_W'(mk_pos);
                end else if (addr_i == OFS_WIDTH) begin
                    rdata_o <= DATA_W'(mk_width);
                end else if (addr_i == OFS_OFFSET) begin
                    rdata_o <= ctrl.common ? DATA_W'(xoffset) : '0;
                end else if (addr_i == OFS_DIV1) begin
                    rdata_o <= DATA_W'(div1);
                end else if (addr_i == OFS_DIV2) begin
                    rdata_o <= DATA_W'(div2);
                end else if (addr_i == OFS_EXTFREQ) begin
                    rdata_o <= (ext1_ok || ext2_ok) ? ext_freq : '0;
                end else if (addr_i == OFS_FMODE) begin
                    rdata_o <= DATA_W'(fmode);
                end else if (addr_i == OFS_LEN1) begin
                    rdata_o <= DATA_W'(len1);
                end else if (addr_i == OFS_LEN2) begin
                    rdata_o <= DATA_W'(len2);
                end else if (addr_i == OFS_STATUS) begin
                    rdata_o <= DATA_W'({ext_freq_set && (ext1_ok || ext2_ok),
                                        ext2_ok, ext1_ok, marker_o});
                end else if (addr_i == OFS_CNT1) begin
                    rdata_o <= DATA_W'(pos1);
                end else if (addr_i == OFS_CNT2) begin
                    rdata_o <= DATA_W'(pos2);
                end
            end
        end
    end

    // sample clock routing
    assign ext1_ok = ctrl.ext1 && ext_allowed(fmode[FMODE_CH1_LSB +: 2]);
    assign ext2_ok = ctrl.ext2 && !ctrl.common
                     && ext_allowed(fmode[FMODE_CH2_LSB +: 2]);

    mscr_clk_div u_div1 (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .ext_clk_i (ext_clk_i),
        .div_log_i (div1),
        .tick_o    (ext_tick[0])
    );

    mscr_clk_div u_div2 (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .ext_clk_i (ext_clk_i),
        .div_log_i (div2),
        .tick_o    (ext_tick[1])
    );

    always_comb begin
        tick[0] = ext1_ok ? (ext_tick[0] && ext_freq_set) : int_tick_i[0];
        if (ctrl.common) begin
            tick[1] = tick[0];
        end else begin
            tick[1] = ext2_ok ? (ext_tick[1] && ext_freq_set) : int_tick_i[1];
        end
    end

    assign sample_tick_o = ce_i ? tick : 2'b00;

    // playback position
    assign run2     = ctrl.common ? run_i[0] : run_i[1];
    assign len2_eff = ctrl.common ? len1 : len2;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            run_q <= '0;
        end else if (ce_i) begin
            run_q <= {run2, run_i[0]};
        end
    end

    assign start = {run2 & ~run_q[1], run_i[0] & ~run_q[0]};

    // second channel lags the first by the offset, wrapped into the waveform
    always_comb begin
        load2 = '0;
        if (ctrl.common && xoffset != '0) begin
            if (xoffset > 0) begin
                if (xoffset[POS_W-1:0] < len2_eff) begin
                    load2 = len2_eff - xoffset[POS_W-1:0];
                end
            end else if (POS_W'(-xoffset) < len2_eff) begin
                load2 = POS_W'(-xoffset);
            end
        end
    end

    mscr_sample_ctr u_ctr1 (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .start_i (start[0]),
        .run_i   (run_i[0]),
        .tick_i  (tick[0]),
        .len_i   (len1),
        .load_i  ('0),
        .pos_o   (pos1),
        .last_o  (last[0])
    );

    mscr_sample_ctr u_ctr2 (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .start_i (start[1]),
        .run_i   (run2),
        .tick_i  (tick[1]),
        .len_i   (len2_eff),
        .load_i  (load2),
        .pos_o   (pos2),
        .last_o  (last[1])
    );

    // marker source
    always_comb begin
        if (ctrl.source && DUAL) begin
            sel_pos  = pos2;
            sel_len  = len2_eff;
            sel_tick = tick[1];
            sel_last = last[1];
            sel_run  = run2;
        end else begin
            sel_pos  = pos1;
            sel_len  = len1;
            sel_tick = tick[0];
            sel_last = last[0];
            sel_run  = run_i[0];
        end
    end

    // window re-evaluated each repetition as the counter wraps
    assign in_window = sel_run && (sel_pos >= mk_pos)
                       && ({1'b0, sel_pos} < ({1'b0, mk_pos} + {1'b0, mk_width}))
                       && (sel_pos < sel_len);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wstate <= WAVEFORM_COMPLETE_MARKER_IDLE;
            wcount <= '0;
        end else if (ce_i) begin
            case (wstate)
                WAVEFORM_COMPLETE_MARKER_IDLE: begin
                    if (sel_last) begin
                        wstate <= WAVEFORM_COMPLETE_MARKER_ACTIVE;
                        wcount <= '0;
                    end
                end
                WAVEFORM_COMPLETE_MARKER_ACTIVE: begin
                    if (sel_tick) begin
                        if (wcount >= WAVEFORM_COMPLETE_MARKER_SAMPLES - 24'h000001) begin
                            wstate <= WAVEFORM_COMPLETE_MARKER_IDLE;
                        end else begin
                            wcount <= wcount + 24'h000001;
                        end
                    end
                end
                default: begin
                    wstate <= WAVEFORM_COMPLETE_MARKER_IDLE;
                end
            endcase
        end
    end

    assign waveform_complete_marker_level = (wstate == WAVEFORM_COMPLETE_MARKER_ACTIVE);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            marker_o <= 1'b0;
            led_o    <= 1'b0;
        end else if (ce_i) begin
            led_o <= ctrl.enable;
            if (!ctrl.enable) begin
                marker_o <= 1'b0;
            end else if (ctrl.waveform_complete_marker) begin
                marker_o <= waveform_complete_marker_level;
            end else begin
                marker_o <= in_window;
            end
        end
    end
endmodule // mscr_top

// file: verif/mscr_marker_rx.sv
`timescale 1ns/100ps
module mscr_marker_rx (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        marker_i,
    output logic             done_o,
    output logic [15:0]      width_o
);
    logic [15:0] run_len;
    logic        last;

    // reports the length in cycles of each high pulse once it has ended
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            run_len <= '0;
            last    <= 1'b0;
            done_o  <= 1'b0;
            width_o <= '0;
        end else begin
            last    <= marker_i;
            done_o  <= last && !marker_i;
            width_o <= run_len;
            run_len <= marker_i ? run_len + 16'h0001 : 16'h0000;
        end
    end
endmodule // mscr_marker_rx

// file: verif/mscr_top_asserts.sv
`timescale 1ns/100ps
module mscr_top_asserts
    import mscr_pkg::*;
#(
    parameter bit DUAL = 1'b1
) (
    input  wire logic              clock_i,
    input  wire logic              reset_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    input  wire logic [DATA_W-1:0] rdata_o,
    input  wire logic [1:0]        int_tick_i,
    input  wire logic              ext_clk_i,
    input  wire logic [1:0]        run_i,
    input  wire logic [1:0]        sample_tick_o,
    input  wire logic              marker_o,
    input  wire logic              led_o
);
    logic common_sh;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // shadow of the common feed bit as software last wrote it
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            common_sh <= 1'b0;
        end else if (ce_i && wr_i && addr_i == OFS_CTRL) begin
            common_sh <= DUAL && wdata_i[CTRL_COMMON];
        end
    end

    sequence s_read(logic [ADDR_W-1:0] a);
        ce_i && rd_i && addr_i == a;
    endsequence
    sequence s_ctrl_write;
        ce_i && wr_i && addr_i == OFS_CTRL ##1 !(wr_i && addr_i == OFS_CTRL);
    endsequence

    property p_reset_dark;
        $fell(reset_i) |-> !marker_o && !led_o && rdata_o == '0;
    endproperty
    a_reset_dark: assert property (p_reset_dark) else $error("outputs active after reset");
    property p_led_follows;
        s_ctrl_write |-> ##1 led_o == $past(wdata_i[CTRL_ENABLE], 2);
    endproperty
    a_led_follows: assert property (p_led_follows) else $error("indicator not following enable");
    property p_dark_quiet;
        !led_o |-> !marker_o;
    endproperty
    a_dark_quiet: assert property (p_dark_quiet) else $error("marker while disabled");
    property p_pos_step;
        s_read(OFS_POS) |=> rdata_o[STEP_BITS-1:0] == '0;
    endproperty
    a_pos_step: assert property (p_pos_step) else $error("position not in steps");
    property p_offset_locked;
        s_read(OFS_OFFSET) ##0 !common_sh |=> rdata_o == '0;
    endproperty
    a_offset_locked: assert property (p_offset_locked) else $error("offset visible");
    property p_freq_gated;
        s_read(OFS_STATUS) |=> !rdata_o[3] || rdata_o[1] || rdata_o[2];
    endproperty
    a_freq_gated: assert property (p_freq_gated) else $error("freq set without selection");
    property p_pulse_min;
        $rose(marker_o) |-> (marker_o || !led_o)[*8] ##1 (marker_o || !led_o)[*8];
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("marker pulse too short");
    property p_tick_common;
        common_sh |-> sample_tick_o[1] == sample_tick_o[0];
    endproperty
    a_tick_common: assert property (p_tick_common) else $error("channels not on one feed");
endmodule // mscr_top_asserts

bind mscr_top mscr_top_asserts #(.DUAL(DUAL)) i_mscr_top_asserts (
    .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .int_tick_i(int_tick_i), .ext_clk_i(ext_clk_i), .run_i(run_i),
    .sample_tick_o(sample_tick_o), .marker_o(marker_o), .led_o(led_o)
);

// file: verif/mscr_top_test.sv
`timescale 1ns/100ps
module mscr_top_test;
    import mscr_pkg::*;
    logic              clock_i, reset_i, ce_i, wr_i, rd_i, ext_clk_i, marker_o, led_o, rx_done;
    logic              rd_seen = 1'b0;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, seed, v;
    logic [1:0]        int_tick_i, run_i, sample_tick_o;
    logic [15:0]       rx_width;
    logic [DATA_W-1:0] exp_rd[$];
    int                exp_w[$];
    int                bad_count = 0, checks = 0, c0, c1;

    mscr_top #(.DUAL(1'b1)) i_mscr_top (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .int_tick_i(int_tick_i), .ext_clk_i(ext_clk_i), .run_i(run_i),
        .sample_tick_o(sample_tick_o), .marker_o(marker_o), .led_o(led_o)
    );
    mscr_marker_rx i_mscr_marker_rx (
        .clock_i(clock_i), .reset_i(reset_i), .marker_i(marker_o),
        .done_o(rx_done), .width_o(rx_width)
    );

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic cmp(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_rd.push_back(e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
    endtask

    // toggles the external clock every cycle and counts both sample ticks
    task automatic count_ticks(input int n);
        c0 = 0;
        c1 = 0;
        repeat (n) begin
            @(posedge clock_i);
            ext_clk_i <= ~ext_clk_i;
            c0 += (sample_tick_o[0] === 1'b1);
            c1 += (sample_tick_o[1] === 1'b1);
        end
    endtask

    // restart playback, enable early in the waveform, await one pulse, disable
    task automatic marker_run(input logic [DATA_W-1:0] ctrl, input int w);
        int n;
        n = 0;
        run_i <= 2'b00;
        @(posedge clock_i);
        run_i <= 2'b11;
        wr(OFS_CTRL, ctrl);
        exp_w.push_back(w);
        while (exp_w.size() != 0 && n < 600) begin
            @(posedge clock_i);
            n++;
        end
        wr(OFS_CTRL, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        if (rd_seen === 1'b1) begin
            cmp("rdata", exp_rd.pop_front(), rdata_o);
        end
        rd_seen <= rd_i;
        if (rx_done === 1'b1) begin
            if (exp_w.size() == 0) begin
                cmp("stray marker", 32'h0, {16'h0, rx_width});
            end else begin
                cmp("marker width", exp_w.pop_front(), {16'h0, rx_width});
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        cmp("watchdog", 32'h0, 32'h1);
        wrap_up();
    end

    initial begin
        reset_i    = 1'b1;
        ce_i       = 1'b1;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        addr_i     = '0;
        wdata_i    = '0;
        int_tick_i = 2'b11;
        ext_clk_i  = 1'b0;
        run_i      = 2'b00;
        seed       = 32'h9588;
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_POS, 32'h0);
        rd(OFS_WIDTH, 32'h10);
        repeat (3) begin
            seed = xs(seed);
            wr(OFS_POS, seed);
            rd(OFS_POS, seed & 32'h00FFFFF0);
            seed = xs(seed);
            wr(OFS_WIDTH, seed & 32'h3FF);
            v = seed & 32'h3F0;
            rd(OFS_WIDTH, (v < 32'h10) ? 32'h10 : v);
        end
        wr(OFS_WIDTH, 32'h5);
        rd(OFS_WIDTH, 32'h10);
        wr(OFS_LEN1, 32'h40);
        wr(OFS_LEN2, 32'h80);
        wr(OFS_POS, 32'h10);
        wr(OFS_WIDTH, 32'h20);
        marker_run(32'h1, 32);
        wr(OFS_POS, 32'h30);
        marker_run(32'h1, 16);
        marker_run(32'h3, 32);
        marker_run(32'h5, 16);
        marker_run(32'h7, 16);
        repeat (300) @(posedge clock_i);
        cmp("led", 32'h0, {31'h0, led_o});
        for (int m = 0; m < 4; m++) begin
            wr(OFS_FMODE, m * 5);
            wr(OFS_CTRL, 32'h30);
            rd(OFS_CTRL, (m == 1 || m == 2) ? 32'h30 : 32'h0);
        end
        wr(OFS_EXTFREQ, 32'h5);
        rd(OFS_EXTFREQ, 32'h0);
        wr(OFS_FMODE, 32'h1);
        wr(OFS_CTRL, 32'h10);
        wr(OFS_DIV1, 32'h9);
        rd(OFS_DIV1, 32'h0);
        wr(OFS_DIV1, 32'h2);
        rd(OFS_DIV1, 32'h2);
        count_ticks(80);
        cmp("ext ticks early", 32'h0, c0);
        wr(OFS_EXTFREQ, 32'h5);
        rd(OFS_EXTFREQ, 32'h5);
        rd(OFS_STATUS, 32'hA);
        count_ticks(400);
        cmp("ext ticks in range", 32'h1, (c0 >= 49 && c0 <= 51));
        cmp("int ticks", 32'd400, c1);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_OFFSET, 32'h7);
        rd(OFS_OFFSET, 32'h0);
        wr(OFS_CTRL, 32'h8);
        rd(OFS_CTRL, 32'h8);
        wr(OFS_DIV2, 32'h3);
        rd(OFS_DIV2, 32'h0);
        wr(OFS_LEN2, 32'h20);
        rd(OFS_LEN2, 32'h80);
        wr(OFS_OFFSET, 32'h14);
        rd(OFS_OFFSET, 32'h14);
        run_i <= 2'b00;
        @(posedge clock_i);
        run_i <= 2'b11;
        rd(OFS_CNT1, 32'h0);
        // second channel starts at length minus offset, two ticks on
        rd(OFS_CNT2, 32'h2E);
        ce_i <= 1'b0;
        wr(OFS_POS, 32'h50);
        ce_i <= 1'b1;
        rd(OFS_POS, 32'h30);
        repeat (20) begin
            @(posedge clock_i);
            seed = xs(seed);
            int_tick_i <= seed[1:0];
        end
        reset_i <= 1'b1;
        @(posedge clock_i);
        reset_i <= 1'b0;
        rd(OFS_CTRL, 32'h0);
        repeat (4) @(posedge clock_i);
        cmp("pending", 32'h0, exp_w.size() + exp_rd.size());
        wrap_up();
    end
endmodule // mscr_top_test
